// [hdl/eeprom_pkg.sv]
// Purpose: Shared constants and types of the two-wire EEPROM slave.
// Assumes: Core clock 200 MHz, oversampling link clock 15 ns.
// Notes:   Counts are derived from times; long counts become top parameters.
`default_nettype none

package eeprom_pkg;

  // ----------------------------------------------------------------
  // Clocks and times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int LINK_PERIOD_PS  = 15000;
  localparam int PROG_TIME_HI_MS = 10;
  localparam int PROG_TIME_LO_MS = 15;
  localparam int FILTER_STD_NS   = 100;
  localparam int FILTER_FAST_NS  = 50;

  // Longest times round down, least times round up
  localparam int PROG_HI_CYCLES  = PROG_TIME_HI_MS * 1000 * CLK_MHZ;
  localparam int PROG_LO_CYCLES  = PROG_TIME_LO_MS * 1000 * CLK_MHZ;
  localparam int PROG_CNT_W      = 22;
  localparam int FILTER_STD_CYC  = (FILTER_STD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int FILTER_FAST_CYC = (FILTER_FAST_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int FILTER_CNT_W    = 3;

  // ----------------------------------------------------------------
  // Slave address layout
  // ----------------------------------------------------------------
  // Type code value is arbitrary
  localparam logic [3:0] TYPE_CODE     = 4'h6;
  localparam int         SA_RW_BIT     = 0;
  localparam int         SA_BLOCK_BIT  = 1;
  localparam int         SA_STRAP1_BIT = 2;
  localparam int         SA_STRAP2_BIT = 3;
  localparam int         SA_TYPE_LSB   = 4;
  localparam logic       DIR_READ      = 1'b1;

  // ----------------------------------------------------------------
  // Memory organisation
  // ----------------------------------------------------------------
  localparam int         BYTE_BITS   = 8;
  localparam int         ADDR_W      = 8;
  localparam int         PAGE_IDX_W  = 4;
  localparam int         PAGE_BYTES  = 16;
  localparam int         BLOCK_BYTES = 256;
  localparam int         NUM_BLOCKS  = 2;
  localparam int         MEM_IDX_W   = 9;
  localparam int         BIT_CNT_W   = 4;
  localparam logic       PROT_BLOCK  = 1'b1;
  localparam logic       SDA_LEVEL   = 1'b0;
  localparam logic       LINE_IDLE   = 1'b1;

  typedef enum {
    ST_IDLE, ST_DEVADDR, ST_DEVACK, ST_WORDADDR, ST_WORDACK,
    ST_WRDATA, ST_WRACK, ST_RDDATA, ST_RDACK, ST_WAITSTOP
  } link_state_t;

endpackage : eeprom_pkg

`default_nettype wire

// [hdl/glitch_filter.sv]
// Purpose: Synchronise a bus pin and suppress pulses shorter than a limit.
// Assumes: Runs on the free-running oversampling link clock.
// Notes:   Filtered level comes from a flop; idle level is high.
`default_nettype none

module glitch_filter #(
  parameter int STD_CYCLES  = eeprom_pkg::FILTER_STD_CYC,
  parameter int FAST_CYCLES = eeprom_pkg::FILTER_FAST_CYC,
  parameter int CNT_W       = eeprom_pkg::FILTER_CNT_W
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pinIn,
  input  wire logic fastMode,
  output var  logic filtered
);

  logic             s1Q;
  logic             s2Q;
  logic [CNT_W-1:0] cntQ;
  logic [CNT_W-1:0] limit;
  logic             differs;
  logic             settled;

  assign limit   = fastMode ? CNT_W'(FAST_CYCLES - 1) : CNT_W'(STD_CYCLES - 1);
  assign differs = s2Q != filtered;
  assign settled = cntQ >= limit;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1Q <= eeprom_pkg::LINE_IDLE;
      s2Q <= eeprom_pkg::LINE_IDLE;
    end else begin
      s1Q <= pinIn;
      s2Q <= s1Q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cntQ     <= '0;
      filtered <= eeprom_pkg::LINE_IDLE;
    end else if (!differs) begin
      cntQ     <= '0;
    end else if (settled) begin
      cntQ     <= '0;
      filtered <= s2Q;
    end else begin
      cntQ     <= cntQ + CNT_W'(1);
    end
  end

endmodule : glitch_filter

`default_nettype wire

// [hdl/program_timer.sv]
// Purpose: Time the self-timed program cycle in the core clock domain.
// Assumes: Request arrives as a toggle from the link domain.
// Notes:   A request during a running cycle restarts the count.
`default_nettype none

module program_timer #(
  parameter int HI_CYCLES = eeprom_pkg::PROG_HI_CYCLES,
  parameter int LO_CYCLES = eeprom_pkg::PROG_LO_CYCLES,
  parameter int CNT_W     = eeprom_pkg::PROG_CNT_W
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic reqToggle,
  input  wire logic lowSupply,
  output var  logic busy
);

  logic             t1Q;
  logic             t2Q;
  logic             t3Q;
  logic             ls1Q;
  logic             ls2Q;
  logic [CNT_W-1:0] cntQ;
  logic             reqSeen;
  logic [CNT_W-1:0] loadVal;

  assign reqSeen = t2Q ^ t3Q;
  // Supply level is a pin, so it is synchronised before it picks the count
  assign loadVal = ls2Q ? CNT_W'(LO_CYCLES - 1) : CNT_W'(HI_CYCLES - 1);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      t1Q <= 1'b0;
      t2Q <= 1'b0;
      t3Q <= 1'b0;
      ls1Q <= 1'b0;
      ls2Q <= 1'b0;
    end else begin
      t1Q <= reqToggle;
      t2Q <= t1Q;
      t3Q <= t2Q;
      ls1Q <= lowSupply;
      ls2Q <= ls1Q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cntQ <= '0;
      busy <= 1'b0;
    end else if (reqSeen) begin
      cntQ <= loadVal;
      busy <= 1'b1;
    end else if (cntQ != '0) begin
      cntQ <= cntQ - CNT_W'(1);
    end else begin
      busy <= 1'b0;
    end
  end

endmodule : program_timer

`default_nettype wire

// [hdl/eeprom_twowire_slave.sv]
// Purpose: Slave addressing, acknowledge and array access of a 4-kbit
//          two-wire EEPROM.
// Assumes: linkClk is a free-running oversampling clock; pins are async.
// Notes:   Array writes land at the STOP; the timer then blocks the bus.
`default_nettype none

module eeprom_twowire_slave #(
  parameter int PROG_HI_CYCLES = eeprom_pkg::PROG_HI_CYCLES,
  parameter int PROG_LO_CYCLES = eeprom_pkg::PROG_LO_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic linkClk,
  input  wire logic scl,
  input  wire logic sdaIn,
  output var  logic sdaOut,
  output var  logic sdaOe,
  input  wire logic strapSelectBit1,
  input  wire logic strapSelectBit2,
  input  wire logic writeProtect,
  input  wire logic fastMode,
  input  wire logic lowSupply,
  output var  logic programBusy
);

  localparam int BW   = eeprom_pkg::BYTE_BITS;
  localparam int AW   = eeprom_pkg::ADDR_W;
  localparam int PW   = eeprom_pkg::PAGE_IDX_W;
  localparam int NPG  = eeprom_pkg::PAGE_BYTES;
  localparam int CW   = eeprom_pkg::BIT_CNT_W;
  localparam int MW   = eeprom_pkg::MEM_IDX_W;
  localparam int MEMN = eeprom_pkg::BLOCK_BYTES * eeprom_pkg::NUM_BLOCKS;
  localparam int SYNW = 4;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // block bit above byte address
  function automatic logic [MW-1:0] memIdx(input logic blk, input logic [AW-1:0] adr);
    memIdx = {blk, adr};
  endfunction : memIdx

  // ----------------------------------------------------------------
  // Crossing of slow levels into the link domain
  // ----------------------------------------------------------------
  logic [SYNW-1:0] syncAQ;
  logic [SYNW-1:0] syncBQ;
  logic [SYNW-1:0] asyncIn;
  logic            strap1;
  logic            strap2;
  logic            wpLink;
  logic            fastLink;
  logic            busyRaw;

  assign asyncIn  = {fastMode, writeProtect, strapSelectBit2, strapSelectBit1};
  assign strap1   = syncBQ[0];
  assign strap2   = syncBQ[1];
  assign wpLink   = syncBQ[2];
  assign fastLink = syncBQ[3];

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      syncAQ <= '0;
      syncBQ <= '0;
    end else begin
      syncAQ <= asyncIn;
      syncBQ <= syncAQ;
    end
  end

  logic busyAQ;
  logic busyBQ;
  logic pendingQ;
  logic busyLink;

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      busyAQ <= 1'b0;
      busyBQ <= 1'b0;
    end else begin
      busyAQ <= busyRaw;
      busyBQ <= busyAQ;
    end
  end

  // Covers the gap until the timer's busy has crossed back
  assign busyLink = pendingQ | busyBQ;

  // ----------------------------------------------------------------
  // Pin filtering and bus conditions
  // ----------------------------------------------------------------
  logic sclF;
  logic sdaF;
  logic sclPrevQ;
  logic sdaPrevQ;

  glitch_filter u_scl_filter (
    .clk      (linkClk),
    .reset    (reset),
    .pinIn    (scl),
    .fastMode (fastLink),
    .filtered (sclF)
  );

  glitch_filter u_sda_filter (
    .clk      (linkClk),
    .reset    (reset),
    .pinIn    (sdaIn),
    .fastMode (fastLink),
    .filtered (sdaF)
  );

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      sclPrevQ <= eeprom_pkg::LINE_IDLE;
      sdaPrevQ <= eeprom_pkg::LINE_IDLE;
    end else begin
      sclPrevQ <= sclF;
      sdaPrevQ <= sdaF;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclRise   = sclF & ~sclPrevQ;
  assign sclFall   = ~sclF & sclPrevQ;
  assign startCond = sclF & sclPrevQ & sdaPrevQ & ~sdaF;
  assign stopCond  = sclF & sclPrevQ & ~sdaPrevQ & sdaF;

  // ----------------------------------------------------------------
  // Link state and datapath
  // ----------------------------------------------------------------
  eeprom_pkg::link_state_t stateQ, stateD;
  logic [CW-1:0]  bitCntQ, bitCntD;
  logic [BW-1:0]  rxQ, rxD;
  logic [BW-1:0]  txQ, txD;
  logic           oeD;
  logic [AW-1:0]  addrQ, addrD;
  logic           blockQ, blockD;
  logic           rwQ, rwD;
  logic           mAckQ, mAckD;
  logic [NPG-1:0] validQ, validD;
  logic           bufWe;
  logic           commit;
  logic           progTogQ;
  logic [BW-1:0]  memQ [MEMN];
  logic [BW-1:0]  bufQ [NPG];

  logic          shifting;
  logic          byteIn;
  logic          typeOk;
  logic          strapOk;
  logic          devMatch;
  logic          protHit;
  logic [AW-1:0] nextAddr;
  logic [AW-1:0] nextInPage;
  logic [BW-1:0] rdNow;
  logic [BW-1:0] rdNext;

  assign shifting = stateQ == eeprom_pkg::ST_DEVADDR || stateQ == eeprom_pkg::ST_WORDADDR
                 || stateQ == eeprom_pkg::ST_WRDATA  || stateQ == eeprom_pkg::ST_RDDATA;
  assign byteIn   = bitCntQ == CW'(BW);
  assign typeOk   = rxQ[BW-1:eeprom_pkg::SA_TYPE_LSB] == eeprom_pkg::TYPE_CODE;
  assign strapOk  = rxQ[eeprom_pkg::SA_STRAP1_BIT] == strap1
                 && rxQ[eeprom_pkg::SA_STRAP2_BIT] == strap2;
  assign devMatch = typeOk & strapOk & ~busyLink;
  assign protHit  = wpLink & (blockQ == eeprom_pkg::PROT_BLOCK);
  assign nextAddr = addrQ + AW'(1);
  assign nextInPage = {addrQ[AW-1:PW], nextAddr[PW-1:0]};
  assign rdNow    = memQ[memIdx(blockQ, addrQ)];
  // roll over inside the 256-byte block, across page ends
  assign rdNext   = memQ[memIdx(blockQ, nextAddr)];

  always_comb begin
    stateD  = stateQ;
    bitCntD = bitCntQ;
    rxD     = rxQ;
    txD     = txQ;
    oeD     = sdaOe;
    addrD   = addrQ;
    blockD  = blockQ;
    rwD     = rwQ;
    mAckD   = mAckQ;
    validD  = validQ;
    bufWe   = 1'b0;
    commit  = 1'b0;
    if (stopCond) begin
      oeD    = 1'b0;
      stateD = eeprom_pkg::ST_IDLE;
      if (validQ != '0) begin
        commit = 1'b1;
        validD = '0;
      end
    end else if (startCond) begin
      oeD     = 1'b0;
      bitCntD = '0;
      stateD  = busyLink ? eeprom_pkg::ST_IDLE : eeprom_pkg::ST_DEVADDR;
    end else begin
      if (sclRise && shifting) begin
        rxD     = {rxQ[BW-2:0], sdaF};
        bitCntD = bitCntQ + CW'(1);
      end
      case (stateQ)
        eeprom_pkg::ST_DEVADDR: begin
          if (sclFall && byteIn) begin
            bitCntD = '0;
            if (devMatch) begin
              oeD    = 1'b1;
              rwD    = rxQ[eeprom_pkg::SA_RW_BIT];
              blockD = rxQ[eeprom_pkg::SA_BLOCK_BIT];
              stateD = eeprom_pkg::ST_DEVACK;
            end else begin
              // not ours, wait for next start
              stateD = eeprom_pkg::ST_WAITSTOP;
            end
          end
        end
        eeprom_pkg::ST_DEVACK: begin
          if (sclFall) begin
            if (rwQ == eeprom_pkg::DIR_READ) begin
              txD    = rdNow;
              oeD    = ~rdNow[BW-1];
              stateD = eeprom_pkg::ST_RDDATA;
            end else begin
              oeD    = 1'b0;
              stateD = eeprom_pkg::ST_WORDADDR;
            end
          end
        end
        eeprom_pkg::ST_WORDADDR: begin
          if (sclFall && byteIn) begin
            bitCntD = '0;
            addrD   = rxQ;
            validD  = '0;
            oeD     = 1'b1;
            stateD  = eeprom_pkg::ST_WORDACK;
          end
        end
        eeprom_pkg::ST_WORDACK, eeprom_pkg::ST_WRACK: begin
          if (sclFall) begin
            oeD    = 1'b0;
            stateD = eeprom_pkg::ST_WRDATA;
          end
        end
        eeprom_pkg::ST_WRDATA: begin
          if (sclFall && byteIn) begin
            bitCntD = '0;
            if (protHit) begin
              stateD = eeprom_pkg::ST_WAITSTOP;
            end else begin
              bufWe  = 1'b1;
              validD[addrQ[PW-1:0]] = 1'b1;
              addrD  = nextInPage;
              oeD    = 1'b1;
              stateD = eeprom_pkg::ST_WRACK;
            end
          end
        end
        eeprom_pkg::ST_RDDATA: begin
          if (sclFall) begin
            if (byteIn) begin
              bitCntD = '0;
              oeD     = 1'b0;
              stateD  = eeprom_pkg::ST_RDACK;
            end else begin
              txD = {txQ[BW-2:0], 1'b0};
              oeD = ~txQ[BW-2];
            end
          end
        end
        eeprom_pkg::ST_RDACK: begin
          if (sclRise) begin
            mAckD = ~sdaF;
          end
          if (sclFall) begin
            addrD = nextAddr;
            if (mAckQ) begin
              txD    = rdNext;
              oeD    = ~rdNext[BW-1];
              stateD = eeprom_pkg::ST_RDDATA;
            end else begin
              stateD = eeprom_pkg::ST_WAITSTOP;
            end
          end
        end
        eeprom_pkg::ST_IDLE, eeprom_pkg::ST_WAITSTOP: begin
          oeD = 1'b0;
        end
        default: begin
          oeD    = 1'b0;
          stateD = eeprom_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      stateQ  <= eeprom_pkg::ST_IDLE;
      bitCntQ <= '0;
      rxQ     <= '0;
      txQ     <= '0;
      sdaOe   <= 1'b0;
      addrQ   <= '0;
    end else begin
      stateQ  <= stateD;
      bitCntQ <= bitCntD;
      rxQ     <= rxD;
      txQ     <= txD;
      sdaOe   <= oeD;
      addrQ   <= addrD;
    end
  end

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      blockQ <= 1'b0;
      rwQ    <= 1'b0;
      mAckQ  <= 1'b0;
      validQ <= '0;
    end else begin
      blockQ <= blockD;
      rwQ    <= rwD;
      mAckQ  <= mAckD;
      validQ <= validD;
    end
  end

  // Open drain: only a low level is ever driven
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      sdaOut <= eeprom_pkg::SDA_LEVEL;
    end else begin
      sdaOut <= eeprom_pkg::SDA_LEVEL;
    end
  end

  // ----------------------------------------------------------------
  // Page buffer, array and program request
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (bufWe) begin
      bufQ[addrQ[PW-1:0]] <= rxQ;
    end
  end

  // every buffered byte of the page lands in one cycle
  always_ff @(posedge linkClk) begin
    if (commit) begin
      for (int i = 0; i < NPG; i++) begin
        if (validQ[i]) begin
          memQ[memIdx(blockQ, {addrQ[AW-1:PW], PW'(i)})] <= bufQ[i];
        end
      end
    end
  end

  // Set wins over the clear from the crossed busy
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      progTogQ <= 1'b0;
      pendingQ <= 1'b0;
    end else if (commit) begin
      progTogQ <= ~progTogQ;
      pendingQ <= 1'b1;
    end else if (busyBQ) begin
      pendingQ <= 1'b0;
    end
  end

  program_timer #(
    .HI_CYCLES (PROG_HI_CYCLES),
    .LO_CYCLES (PROG_LO_CYCLES)
  ) u_program_timer (
    .clk       (clk),
    .reset     (reset),
    .reqToggle (progTogQ),
    .lowSupply (lowSupply),
    .busy      (busyRaw)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      programBusy <= 1'b0;
    end else begin
      programBusy <= busyRaw;
    end
  end

endmodule : eeprom_twowire_slave

`default_nettype wire

// [testbench/i2c_master_model.sv]
// Purpose: Bus master model that drives SCL and pulls SDA low.
// Assumes: SDA is open drain with a pull-up resolved in the bench.
// Notes:   SCL stands still high between frames.
`default_nettype none

module i2c_master_model #(
  parameter int Q = 40
) (
  input  wire logic clk,
  output var  logic scl,
  output var  logic sdaPull,
  input  wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic q;
    repeat (Q) @(posedge clk);
  endtask : q
  task automatic start;
    sdaPull <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sdaPull <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask : start
  task automatic stop;
    sdaPull <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaPull <= 1'b0;
    q();
  endtask : stop
  // short SCL pulse inside a low phase
  task automatic glitch(input int n);
    scl <= 1'b1;
    repeat (n) @(posedge clk);
    scl <= 1'b0;
    q();
  endtask : glitch
  task automatic bitX(input logic b, output logic r);
    sdaPull <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sdaWire;
    scl <= 1'b0;
    q();
  endtask : bitX
  task automatic byteX(input logic [7:0] d, input logic ackOut, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitX(d[i], r[i]);
    bitX(!ackOut, a);
    ack = !a;
  endtask : byteX
endmodule : i2c_master_model

`default_nettype wire

// [testbench/eeprom_twowire_slave_checker.sv]
// Purpose: Port-level checks of the two-wire EEPROM slave.
// Assumes: Sees only the top ports; bound below.
// Notes:   Busy length is judged against the supply level before busy rose.
`default_nettype none

module eeprom_twowire_slave_checker #(
  parameter int PROG_HI_CYCLES = 3000,
  parameter int PROG_LO_CYCLES = 4500
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic strapSelectBit1,
  input wire logic strapSelectBit2,
  input wire logic writeProtect,
  input wire logic fastMode,
  input wire logic lowSupply,
  input wire logic programBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [21:0] busyCnt;
  logic        lsQ;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busyCnt <= '0;
      lsQ     <= 1'b0;
    end else begin
      busyCnt <= programBusy ? busyCnt + 22'h1 : '0;
      lsQ     <= programBusy ? lsQ : lowSupply;
    end
  end
  sequence busStart;
    scl && $fell(sdaIn);
  endsequence
  sequence busyHold;
    programBusy [*8];
  endsequence
  a_drive_low_only: assert property (@(posedge linkClk) disable iff (reset)
    sdaOe |-> sdaOut == eeprom_pkg::SDA_LEVEL) else $error("SDA driven high");
  a_change_scl_low: assert property (@(posedge linkClk) disable iff (reset)
    $changed(sdaOe) |-> !scl) else $error("SDA moved under high SCL");
  a_start_line_free: assert property (@(posedge linkClk) disable iff (reset)
    busStart |-> !sdaOe) else $error("Device pulled SDA at start");
  a_busy_no_drive: assert property (@(posedge clk) disable iff (reset)
    programBusy |-> !sdaOe) else $error("SDA driven while busy");
  a_busy_after_stop: assert property (@(posedge clk) disable iff (reset)
    $rose(programBusy) |-> scl && sdaIn) else $error("Busy without idle bus");
  a_busy_min_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(programBusy) |-> busyHold) else $error("Busy pulse too short");
  a_busy_time_limit: assert property (@(posedge clk) disable iff (reset)
    $fell(programBusy) |-> busyCnt <= (lsQ ? PROG_LO_CYCLES : PROG_HI_CYCLES))
    else $error("Program cycle too long");
  a_reset_quiet: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> !sdaOe && !programBusy) else $error("Outputs active after reset");
endmodule : eeprom_twowire_slave_checker

bind eeprom_twowire_slave eeprom_twowire_slave_checker #(
  .PROG_HI_CYCLES(PROG_HI_CYCLES), .PROG_LO_CYCLES(PROG_LO_CYCLES)
) chk (.clk(clk), .reset(reset), .linkClk(linkClk), .scl(scl), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .strapSelectBit1(strapSelectBit1),
  .strapSelectBit2(strapSelectBit2), .writeProtect(writeProtect),
  .fastMode(fastMode), .lowSupply(lowSupply), .programBusy(programBusy));

`default_nettype wire

// [testbench/eeprom_twowire_slave_bench.sv]
// Purpose: Self-checking bench of the two-wire EEPROM slave.
// Assumes: Short program counts; master model on the far side.
// Notes:   Array is not reset, so reads only touch written bytes.
`default_nettype none

module eeprom_twowire_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam int HI = 3000;
  localparam int LO = 4500;
  localparam logic [3:0] TC = eeprom_pkg::TYPE_CODE;
  typedef struct packed {logic [7:0] sa; logic [1:0] strap; logic ack;} row_t;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin errTotal++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset = 1'b1;
  logic strapSelectBit1 = 1'b0;
  logic strapSelectBit2 = 1'b0;
  logic writeProtect = 1'b0;
  logic fastMode = 1'b0;
  logic lowSupply = 1'b0;
  logic scl;
  logic sdaPull;
  logic sdaOut;
  logic sdaOe;
  logic programBusy;
  logic [7:0] r;
  logic ak;
  int errTotal = 0;
  int compares = 0;
  int t;
  // Open drain: only a low pull wins over the pull-up
  wire sdaWire = (sdaOe ? sdaOut : 1'b1) & !sdaPull;
  row_t rows [6] = '{{TC, 4'h8, 2'b10, 1'b1}, {TC, 4'h2, 2'b00, 1'b1}, {TC, 4'hE, 2'b11, 1'b1},
    {TC ^ 4'h1, 4'h8, 2'b10, 1'b0}, {TC, 4'h8, 2'b11, 1'b0}, {TC, 4'h0, 2'b10, 1'b0}};
  always #2.5 clk = ~clk;
  initial begin
    #1.3;
    forever #7.5 linkClk = ~linkClk;
  end
  eeprom_twowire_slave #(.PROG_HI_CYCLES(HI), .PROG_LO_CYCLES(LO)) uut (
    .clk(clk), .reset(reset), .linkClk(linkClk), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .strapSelectBit1(strapSelectBit1),
    .strapSelectBit2(strapSelectBit2), .writeProtect(writeProtect),
    .fastMode(fastMode), .lowSupply(lowSupply), .programBusy(programBusy));
  i2c_master_model #(.Q(40)) m (.clk(clk), .scl(scl), .sdaPull(sdaPull), .sdaWire(sdaWire));
  function automatic logic [7:0] sa(input logic b, input logic rw);
    return {TC, 2'b10, b, rw};
  endfunction : sa
  task automatic sendB(input logic [7:0] d, input logic e);
    logic [7:0] x;
    logic a;
    m.byteX(d, 1'b0, x, a);
    `CHK(a, e)
  endtask : sendB
  task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d0, d1, input logic e);
    m.start();
    sendB(sa(b, 1'b0), 1'b1);
    sendB(a, 1'b1);
    sendB(d0, e);
    if (e) sendB(d1, 1'b1);
    m.stop();
  endtask : wr
  task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] exp, exp2, input logic more);
    logic [7:0] x;
    logic k;
    m.start();
    sendB(sa(b, 1'b0), 1'b1);
    sendB(a, 1'b1);
    m.start();
    sendB(sa(b, 1'b1), 1'b1);
    m.byteX(8'hFF, more, x, k);
    `CHK(x, exp)
    if (more) begin
      m.byteX(8'hFF, 1'b0, x, k);
      `CHK(x, exp2)
    end
    `CHK(k, 1'b0)
    m.stop();
  endtask : rd
  task automatic waitBusy(input logic lvl, input int n);
    for (int i = 0; i < n && programBusy !== lvl; i++) @(posedge clk);
    `CHK(programBusy, lvl)
  endtask : waitBusy
  // Unfiltered, the extra SCL pulse would shift the address by one bit
  task automatic glitchAddr(input int n);
    logic [7:0] x;
    logic a;
    m.start();
    m.glitch(n);
    m.byteX(sa(1'b0, 1'b0), 1'b0, x, a);
    `CHK(a, 1'b1)
    m.stop();
  endtask : glitchAddr
  task automatic endOfTest;
    $display("Mismatches %0d, compares %0d", errTotal, compares);
    if (errTotal == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : endOfTest
  initial begin
    repeat (80000) @(posedge clk);
    errTotal++;
    endOfTest();
  end
  initial begin
    // Six core cycles cover two link clock edges
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    `CHK(programBusy, 1'b0)
    repeat (40) @(posedge clk);
    foreach (rows[i]) begin
      {strapSelectBit2, strapSelectBit1} <= rows[i].strap;
      repeat (20) @(posedge clk);
      m.start();
      m.byteX(rows[i].sa, 1'b0, r, ak);
      `CHK(ak, rows[i].ack)
      m.stop();
    end
    {strapSelectBit2, strapSelectBit1} <= 2'b10;
    glitchAddr(15);
    wr(1'b1, 8'h2E, 8'hA5, 8'hC3, 1'b1);
    waitBusy(1'b1, 50);
    m.start();
    sendB(sa(1'b1, 1'b0), 1'b0);
    m.stop();
    waitBusy(1'b0, HI + 100);
    lowSupply <= 1'b1;
    wr(1'b0, 8'h2F, 8'h3C, 8'h5A, 1'b1);
    waitBusy(1'b1, 50);
    for (t = 0; t < LO + 100 && programBusy === 1'b1; t++) @(posedge clk);
    `CHK(t > HI && t <= LO, 1'b1)
    fastMode <= 1'b1;
    writeProtect <= 1'b1;
    repeat (20) @(posedge clk);
    glitchAddr(6);
    wr(1'b1, 8'h2F, 8'h00, 8'h00, 1'b0);
    repeat (50) @(posedge clk);
    `CHK(programBusy, 1'b0)
    rd(1'b1, 8'h2E, 8'hA5, 8'hC3, 1'b1);
    rd(1'b1, 8'h2F, 8'hC3, 8'h00, 1'b0);
    rd(1'b0, 8'h2F, 8'h3C, 8'h00, 1'b0);
    rd(1'b0, 8'h20, 8'h5A, 8'h00, 1'b0);
    endOfTest();
  end
endmodule : eeprom_twowire_slave_bench

`default_nettype wire
